// *** rtl/dram_config_pkg.sv ***
// constants, field layout and helpers for the dram configuration register block
// assumes one 25 MHz clock and a 32-bit APB slave port in front of the register
`default_nettype none
package dram_config_pkg;

  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  localparam int unsigned LANES  = 4;      // byte lanes of read data
  localparam int unsigned ADDR_W = 16;     // sdram address width
  localparam int unsigned BANK_W = 3;      // sdram bank width
  localparam int unsigned PADDR_W = 12;    // apb address width

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [PADDR_W-1:0] CFG_OFFSET = 12'h000;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int unsigned MIRROR_BIT  = 29;
  localparam int unsigned SINGLE_BIT  = 27;
  localparam int unsigned MASK_LSB    = 10;
  localparam int unsigned MASK_MSB    = 17;
  localparam int unsigned MPRALL_BIT  = 7;
  localparam int unsigned PINSEL_LSB  = 4;
  localparam int unsigned PINSEL_MSB  = 6;
  localparam int unsigned EIGHT_BIT   = 3;
  localparam int unsigned MODE_LSB    = 0;
  localparam int unsigned MODE_MSB    = 2;

  localparam logic [31:0] WRITABLE  = 32'h2803_FCFF;  // every non-reserved bit
  localparam logic [31:0] CFG_RESET = 32'h0000_040B;  // mask 0x1, eight banks, DDR3
  localparam logic [2:0]  MODE_DDR3 = 3'h3;
  localparam logic [7:0]  MASK_RESET = 8'h01;
  localparam logic [BANK_W-1:0] BANK4_MASK = 3'h3;     // four-bank parts drop the top bit

  // swap A3/A4, A5/A6, A7/A8 as the mirrored rank wires them
  function automatic logic [ADDR_W-1:0] mirror_addr(input logic [ADDR_W-1:0] a);
    mirror_addr = {a[15:9], a[7], a[8], a[5], a[6], a[3], a[4], a[2:0]};
  endfunction

  // swap BA0/BA1 for the mirrored rank
  function automatic logic [BANK_W-1:0] mirror_bank(input logic [BANK_W-1:0] b);
    mirror_bank = {b[2], b[0], b[1]};
  endfunction

endpackage
`default_nettype wire

// *** rtl/lane_compare.sv ***
// one byte lane of the training comparator
// assumes expected data and mask are stable in the cycle the beat is valid
`timescale 1ns/1ps
`default_nettype none
module lane_compare (
  input  wire logic [7:0] laneData,   // received byte
  input  wire logic [7:0] laneExpect, // expected byte
  input  wire logic [7:0] laneMask,   // 1 = bit takes part
  output logic            laneOk      // no unmasked bit differs
);
  // masked-out bits can never cause a miss
  assign laneOk = (((laneData ^ laneExpect) & laneMask) == 8'h00);
endmodule
`default_nettype wire

// *** rtl/dram_config_register.sv ***
// dram configuration register with its command steering and training compare
// assumes APB master in the same clock domain; chip selects are active low pins
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dram_config_register (
  input  wire logic                                  sys_clk,        // 25 MHz
  input  wire logic                                  reset_n,        // sync, low
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [dram_config_pkg::PADDR_W-1:0]   paddr,
  input  wire logic [31:0]                           pwdata,
  output logic      [31:0]                           prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  input  wire logic                                  cmdValid,       // command offered
  output logic                                       cmdReady,       // low while split
  input  wire logic [1:0]                            cmdRank,        // rank request
  input  wire logic [dram_config_pkg::ADDR_W-1:0]    cmdAddr,
  input  wire logic [dram_config_pkg::BANK_W-1:0]    cmdBank,
  output logic      [1:0]                            ddrCs_n,        // chip selects
  output logic      [dram_config_pkg::ADDR_W-1:0]    ddrAddr,
  output logic      [dram_config_pkg::BANK_W-1:0]    ddrBank,
  input  wire logic                                  gateTraining,   // dqs gate training
  input  wire logic                                  mprRead,        // MPR read mode
  input  wire logic                                  readValid,      // one beat
  input  wire logic [dram_config_pkg::LANES*8-1:0]   readData,
  output logic      [dram_config_pkg::LANES-1:0]     laneMatch,
  output logic                                       laneMatchValid,
  output logic      [2:0]                            memoryTypeMode,
  output logic                                       ddr3Selected,
  output logic                                       eightBankFlag,
  output logic      [2:0]                            primaryDataPinSelect
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] cfg_q;     // dram_configuration
  logic [31:0] cfg_d;
  logic [31:0] prdata_q;  // read data, loaded in the setup cycle
  logic [31:0] prdata_d;
  logic        hit;       // address decodes to the register
  logic        wrEn;      // write commits in the access cycle

  logic       secondRankAddressMirror;
  logic       singleRankPerCycle;
  logic [7:0] gateTrainingCompareMask;
  logic       mprPatternAllPins;

  assign hit     = (paddr == dram_config_pkg::CFG_OFFSET);
  assign wrEn    = psel & penable & pwrite & hit;
  assign pready  = psel & penable;           // zero wait states
  assign pslverr = psel & penable & ~hit;    // unmapped offsets error out
  assign prdata  = prdata_q;

  // next register value: reserved bits are forced to zero on every write
  always_comb begin
    cfg_d    = cfg_q;
    prdata_d = prdata_q;
    if (wrEn) begin
      cfg_d = pwdata & dram_config_pkg::WRITABLE;
    end
    if (psel & ~penable) begin
      prdata_d = hit ? (cfg_q & dram_config_pkg::WRITABLE) : 32'h0000_0000;
    end
  end

  // register stage; reset values select DDR3, eight banks, mask of bit 0
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cfg_q    <= dram_config_pkg::CFG_RESET;
      prdata_q <= 32'h0000_0000;
    end else begin
      cfg_q    <= cfg_d;
      prdata_q <= prdata_d;
    end
  end

  // field views
  assign secondRankAddressMirror = cfg_q[dram_config_pkg::MIRROR_BIT];
  assign singleRankPerCycle      = cfg_q[dram_config_pkg::SINGLE_BIT];
  assign gateTrainingCompareMask = cfg_q[dram_config_pkg::MASK_MSB:dram_config_pkg::MASK_LSB];
  assign mprPatternAllPins       = cfg_q[dram_config_pkg::MPRALL_BIT];
  assign memoryTypeMode          = cfg_q[dram_config_pkg::MODE_MSB:dram_config_pkg::MODE_LSB];
  assign ddr3Selected            = (memoryTypeMode == dram_config_pkg::MODE_DDR3);
  assign eightBankFlag           = cfg_q[dram_config_pkg::EIGHT_BIT];
  assign primaryDataPinSelect    = cfg_q[dram_config_pkg::PINSEL_MSB:dram_config_pkg::PINSEL_LSB];

  // ----------------------------------------------------------------
  // command steering
  // ----------------------------------------------------------------
  logic                               pending_q;  // second rank still owed
  logic                               pending_d;
  logic [dram_config_pkg::ADDR_W-1:0] heldAddr_q; // address of the split command
  logic [dram_config_pkg::ADDR_W-1:0] heldAddr_d;
  logic [dram_config_pkg::BANK_W-1:0] heldBank_q;
  logic [dram_config_pkg::BANK_W-1:0] heldBank_d;
  logic [1:0]                         cs_q;       // active-high selects
  logic [1:0]                         cs_d;
  logic [dram_config_pkg::ADDR_W-1:0] addr_q;
  logic [dram_config_pkg::ADDR_W-1:0] addr_d;
  logic [dram_config_pkg::BANK_W-1:0] bank_q;
  logic [dram_config_pkg::BANK_W-1:0] bank_d;
  logic [dram_config_pkg::BANK_W-1:0] bankMask;

  assign cmdReady = ~pending_q;
  assign ddrCs_n  = ~cs_q;
  assign ddrAddr  = addr_q;
  assign ddrBank  = bank_q;
  // four-bank parts never see the top bank bit
  assign bankMask = eightBankFlag ? {dram_config_pkg::BANK_W{1'b1}} : dram_config_pkg::BANK4_MASK;

  // a dual-rank request under the single-rank flag is split over two cycles,
  // rank 0 first; the upstream is stalled through cmdReady meanwhile
  always_comb begin
    pending_d  = 1'b0;
    heldAddr_d = heldAddr_q;
    heldBank_d = heldBank_q;
    cs_d       = 2'b00;
    addr_d     = addr_q;
    // an idle bank bus is masked too, so a stale top bit from an eight-bank
    // setting never lingers once the flag is cleared
    bank_d     = bank_q & bankMask;
    if (pending_q) begin
      // owed half goes to the second rank alone
      cs_d = 2'b10;
      if (secondRankAddressMirror) begin
        addr_d = dram_config_pkg::mirror_addr(heldAddr_q);
        bank_d = dram_config_pkg::mirror_bank(heldBank_q) & bankMask;
      end else begin
        addr_d = heldAddr_q;
        bank_d = heldBank_q & bankMask;
      end
    end else if (cmdValid && cmdRank != 2'b00) begin
      addr_d = cmdAddr;
      bank_d = cmdBank & bankMask;
      if (cmdRank == 2'b11 && singleRankPerCycle) begin
        cs_d       = 2'b01;
        pending_d  = 1'b1;
        heldAddr_d = cmdAddr;
        heldBank_d = cmdBank;
      end else begin
        // a shared dual-rank cycle cannot mirror one rank only, so it stays plain;
        // software is expected to set the single-rank flag with mirroring
        cs_d = cmdRank;
        if (cmdRank == 2'b10 && secondRankAddressMirror) begin
          addr_d = dram_config_pkg::mirror_addr(cmdAddr);
          bank_d = dram_config_pkg::mirror_bank(cmdBank) & bankMask;
        end
      end
    end
  end

  // command registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pending_q  <= 1'b0;
      heldAddr_q <= '0;
      heldBank_q <= '0;
      cs_q       <= 2'b00;
      addr_q     <= '0;
      bank_q     <= '0;
    end else begin
      pending_q  <= pending_d;
      heldAddr_q <= heldAddr_d;
      heldBank_q <= heldBank_d;
      cs_q       <= cs_d;
      addr_q     <= addr_d;
      bank_q     <= bank_d;
    end
  end

  // ----------------------------------------------------------------
  // training and MPR compare
  // ----------------------------------------------------------------
  logic                                comparing;   // either compare mode active
  logic                                beatOdd_q;   // 0-1-0-1 pattern phase
  logic                                beatOdd_d;
  logic [7:0]                          expectByte;
  logic [dram_config_pkg::LANES-1:0]   laneOk;
  logic [dram_config_pkg::LANES-1:0]   match_q;
  logic [dram_config_pkg::LANES-1:0]   match_d;
  logic                                matchValid_q;
  logic                                matchValid_d;

  assign comparing      = gateTraining | mprRead;
  assign laneMatch      = match_q;
  assign laneMatchValid = matchValid_q;

  // expected byte: pattern on every pin, or on the primary pin with others zero
  always_comb begin
    if (mprPatternAllPins) begin
      expectByte = {8{beatOdd_q}};
    end else begin
      expectByte = {7'h00, beatOdd_q} << primaryDataPinSelect;
    end
  end

  // one comparator per byte lane, all sharing the one mask
  for (genvar g = 0; g < dram_config_pkg::LANES; g++) begin : gLane
    lane_compare uLane (
      .laneData   (readData[g*8 +: 8]),
      .laneExpect (expectByte),
      .laneMask   (gateTrainingCompareMask),
      .laneOk     (laneOk[g])
    );
  end

  // pattern phase restarts whenever comparison stops
  always_comb begin
    beatOdd_d    = comparing ? (beatOdd_q ^ readValid) : 1'b0;
    matchValid_d = comparing & readValid;
    match_d      = (comparing & readValid) ? laneOk : match_q;
  end

  // compare registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      beatOdd_q    <= 1'b0;
      matchValid_q <= 1'b0;
      match_q      <= '0;
    end else begin
      beatOdd_q    <= beatOdd_d;
      matchValid_q <= matchValid_d;
      match_q      <= match_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence splitReq;
    cmdValid && cmdReady && cmdRank == 2'b11 && singleRankPerCycle;
  endsequence
  sequence splitIssue;
    ddrCs_n == 2'b10 ##1 ddrCs_n == 2'b01;
  endsequence

  reserved_zero_a: assert property (pready && !pwrite && !pslverr |-> (prdata & ~dram_config_pkg::WRITABLE) == 32'h0)
    else $error("reserved bits read nonzero");
  write_lands_a: assert property (wrEn |=> cfg_q == ($past(pwdata) & dram_config_pkg::WRITABLE))
    else $error("write not stored as masked");
  split_order_a: assert property (splitReq |=> splitIssue)
    else $error("dual rank request not split in order");
  one_rank_a: assert property (singleRankPerCycle && $stable(singleRankPerCycle) && !$past(pending_q) |=> ddrCs_n != 2'b00)
    else $error("two chip selects asserted together");
  mirror_path_a: assert property (cmdValid && cmdReady && cmdRank == 2'b10 && secondRankAddressMirror
                                  |=> ddrAddr == dram_config_pkg::mirror_addr($past(cmdAddr)))
    else $error("second rank address not mirrored");
  plain_rank0_a: assert property (cmdValid && cmdReady && cmdRank == 2'b01 |=> ddrAddr == $past(cmdAddr))
    else $error("first rank address altered");
  four_bank_a: assert property (!eightBankFlag && $stable(eightBankFlag) |=> !ddrBank[2])
    else $error("top bank bit driven on four-bank part");
  mask_excl_a: assert property (comparing && readValid && (((readData[7:0] ^ expectByte) & gateTrainingCompareMask) == 8'h00)
                                |=> laneMatchValid && laneMatch[0])
    else $error("masked-out bit caused a miss");
  mask_incl_a: assert property (comparing && readValid && (((readData[7:0] ^ expectByte) & gateTrainingCompareMask) != 8'h00)
                                |=> !laneMatch[0])
    else $error("included bit mismatch not flagged");
  pattern_pin_a: assert property (comparing && !mprPatternAllPins && beatOdd_q
                                  |-> expectByte == (8'h01 << primaryDataPinSelect))
    else $error("MPR pattern not on primary pin only");

endmodule
`default_nettype wire

// *** tb/ddr3_rank_model.sv ***
// behavioural model of the ranks returning read beats for training compares
// assumes the bench requests beats one at a time while a compare mode is on
`timescale 1ns/1ps
`default_nettype none
module ddr3_rank_model (
  input  wire logic        sys_clk,   // system clock
  input  wire logic        reset_n,   // sync reset, low
  input  wire logic        active,    // a compare mode is on
  input  wire logic        beatGo,    // send one beat
  input  wire logic        allPins,   // pattern on every pin
  input  wire logic [2:0]  pinSel,    // pattern pin when not all
  input  wire logic [7:0]  corrupt,   // bits flipped on lane 2
  output logic             readValid, // beat strobe
  output logic [31:0]      readData   // four lanes
);
  logic       phase;                  // pattern phase, 0 on first beat
  logic [7:0] noise = 8'h00;          // idle junk so stale data never matches
  logic [7:0] lane;                   // byte driven on each lane
  // ----------------------------------------------------------------
  // pattern generation
  // ----------------------------------------------------------------
  always_comb lane = allPins ? {8{phase}} : (8'(phase) << pinSel);
  // one beat per request, junk between beats
  always @(posedge sys_clk) begin
    noise <= noise + 8'h5B;
    if (!reset_n || !active) phase <= 1'b0;
    else if (beatGo) phase <= ~phase;
    readValid <= reset_n && active && beatGo;
    readData  <= (reset_n && active && beatGo) ? {lane, lane ^ corrupt, lane, lane} : {4{noise}};
  end
endmodule
`default_nettype wire

// *** tb/dram_config_register_bench.sv ***
// self-checking bench for the dram configuration register block
// assumes zero-wait APB slave and the rank model as read data source
`timescale 1ns/1ps
`default_nettype none
module dram_config_register_bench;
  logic        sys_clk = 1'b0, reset_n = 1'b0;   // clock and reset
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, er;
  logic        cmdValid = 1'b0, cmdReady;        // command side
  logic [1:0]  cmdRank = 2'h0, ddrCs_n;
  logic [15:0] cmdAddr = 16'h0000, ddrAddr;
  logic [2:0]  cmdBank = 3'h0, ddrBank, memoryTypeMode, primaryDataPinSelect;
  logic        gateTraining = 1'b0, mprRead = 1'b0, beatGo = 1'b0, allPins = 1'b0;
  logic [2:0]  pinSel = 3'h0;
  logic [7:0]  corrupt = 8'h00;
  logic        readValid, laneMatchValid, ddr3Selected, eightBankFlag;
  logic [31:0] readData;
  logic [3:0]  laneMatch;
  int          miscompares = 0, checks = 0;
  logic [31:0] wv [4] = '{32'hFFFF_FFFF, 32'h0000_0000, 32'hD7FC_0300, 32'h0801_5475};
  logic [31:0] ev [4] = '{32'h2803_FCFF, 32'h0000_0000, 32'h0000_0000, 32'h0801_5475};
  dram_config_register DUT (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRank(cmdRank), .cmdAddr(cmdAddr), .cmdBank(cmdBank),
    .ddrCs_n(ddrCs_n), .ddrAddr(ddrAddr), .ddrBank(ddrBank), .gateTraining(gateTraining),
    .mprRead(mprRead), .readValid(readValid), .readData(readData), .laneMatch(laneMatch),
    .laneMatchValid(laneMatchValid), .memoryTypeMode(memoryTypeMode), .ddr3Selected(ddr3Selected),
    .eightBankFlag(eightBankFlag), .primaryDataPinSelect(primaryDataPinSelect));
  ddr3_rank_model ranks (.sys_clk(sys_clk), .reset_n(reset_n), .active(gateTraining | mprRead),
    .beatGo(beatGo), .allPins(allPins), .pinSel(pinSel), .corrupt(corrupt), .readValid(readValid),
    .readData(readData));
  // ----------------------------------------------------------------
  // clock, shared tasks
  // ----------------------------------------------------------------
  initial forever #20 sys_clk = ~sys_clk;
  task automatic summarize;
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one APB transfer; bounded wait for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin miscompares++; summarize(); end
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // one command, returns in the cycle its first output stands
  task automatic cmd(input logic [1:0] r, input logic [15:0] a, input logic [2:0] b);
    @(posedge sys_clk);
    cmdValid <= 1'b1; cmdRank <= r; cmdAddr <= a; cmdBank <= b;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    #1;
  endtask
  // one read beat; checks the lane result when it appears
  task automatic beat(input logic [3:0] exp);
    int n;
    @(posedge sys_clk);
    beatGo <= 1'b1;
    @(posedge sys_clk);
    beatGo <= 1'b0;
    for (n = 0; n < 6 && laneMatchValid !== 1'b1; n++) begin @(posedge sys_clk); #1; end
    if (n >= 6) begin miscompares++; summarize(); end
    chk(32'(laneMatch), 32'(exp));
  endtask
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0000_040B);
    chk(32'({ddr3Selected, eightBankFlag, primaryDataPinSelect}), 32'h18);
    // table rows: written value against read-back and field ports
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, wv[i]);
      apb(1'b0, 12'h000, 32'h0); chk(rd, ev[i]);
      chk(32'({memoryTypeMode, eightBankFlag, primaryDataPinSelect}), 32'({ev[i][2:0], ev[i][3], ev[i][6:4]}));
      chk(32'(ddr3Selected), 32'(ev[i][2:0] == 3'h3));
    end
    // unmapped place is refused and leaves the register alone
    apb(1'b1, 12'h004, 32'hFFFF_FFFF); chk(32'(er), 32'h1);
    apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0801_5475);
    // mid-run reset restores defaults
    @(posedge sys_clk); reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0000_040B);
    // mirroring with single-rank flag: split, second half mirrored
    apb(1'b1, 12'h000, 32'h2800_000B);
    cmd(2'h3, 16'h0028, 3'h1); chk({ddrCs_n, ddrAddr, 11'(ddrBank), 3'(cmdReady)}, 32'h800A_0008);
    step; chk({ddrCs_n, ddrAddr, 14'(ddrBank)}, 32'h4014_0002);
    step; chk(32'(ddrCs_n), 32'h3);
    cmd(2'h2, 16'h0028, 3'h1); chk({ddrCs_n, ddrAddr, 14'(ddrBank)}, 32'h4014_0002);
    // no mirroring, flag clear: both selects together, plain address
    apb(1'b1, 12'h000, 32'h0000_000B);
    cmd(2'h3, 16'h0028, 3'h1); chk({ddrCs_n, ddrAddr, 14'(ddrBank)}, 32'h000A_0001);
    cmd(2'h2, 16'h0028, 3'h1); chk({ddrCs_n, ddrAddr, 14'(ddrBank)}, 32'h400A_0001);
    // four-bank part drops the top bank bit; empty rank request ignored
    apb(1'b1, 12'h000, 32'h0000_0003);
    cmd(2'h1, 16'h0028, 3'h5); chk({ddrCs_n, ddrAddr, 14'(ddrBank)}, 32'h800A_0001);
    cmd(2'h0, 16'h0028, 3'h5); chk(32'(ddrCs_n), 32'h3);
    // gate training compares
    apb(1'b1, 12'h000, 32'h0000_040B);
    @(posedge sys_clk); gateTraining <= 1'b1;
    beat(4'hF); beat(4'hF);
    @(posedge sys_clk); corrupt <= 8'h02;
    beat(4'hF);
    apb(1'b1, 12'h000, 32'h0000_0C0B); beat(4'hB);
    // multi-purpose read compares, pattern placement
    @(posedge sys_clk); gateTraining <= 1'b0; mprRead <= 1'b1; corrupt <= 8'h00; allPins <= 1'b1;
    apb(1'b1, 12'h000, 32'h0003_FC8B); beat(4'hF); beat(4'hF);
    // zero phase matches either placement; the one phase exposes all pins driven
    apb(1'b1, 12'h000, 32'h0003_FC5B); beat(4'hF); beat(4'h0);
    @(posedge sys_clk); allPins <= 1'b0; pinSel <= 3'h5;
    beat(4'hF); beat(4'hF);
    summarize();
  end
endmodule
`default_nettype wire
